//--- dual_wiper_command_engine_test.sv
`timescale 1ns/1ns
module dual_wiper_command_engine_test;
   import dwce_pkg::*;
   typedef struct packed {
      logic [7:0]  w1;
      logic [7:0]  w2;
      logic        rps;
      logic [15:0] rep;
      logic        chk;
   } dwce_note_s;
   logic              ref_clk;
   logic              sys_rst;
   logic              serial_clk;
   logic              cs_n;
   logic              sdi;
   logic              sdo;
   logic              read_power_state;
   logic [CODE_W-1:0] wiper_code_ch1;
   logic [CODE_W-1:0] wiper_code_ch2;
   logic [TAPS-1:0]   tap_sel_ch1;
   logic [TAPS-1:0]   tap_sel_ch2;
   dwce_note_s        notes[$];
   int                error_cnt;
   int                tests_run;
   int                cycles;
   logic [7:0]        w[2];
   logic [7:0]        nv[16];
   logic              rps;
   logic [15:0]       prev_rep;
   logic              rep_ok;
   logic [15:0]       cur_rep;
   logic              cur_chk;
   logic [31:0]       seed;
   event              frame_done;

   dwce_core dut (
      .ref_clk          (ref_clk),
      .sys_rst          (sys_rst),
      .serial_clk       (serial_clk),
      .cs_n             (cs_n),
      .sdi              (sdi),
      .sdo              (sdo),
      .wiper_code_ch1   (wiper_code_ch1),
      .wiper_code_ch2   (wiper_code_ch2),
      .tap_sel_ch1      (tap_sel_ch1),
      .tap_sel_ch2      (tap_sel_ch2),
      .read_power_state (read_power_state)
   );

   dwce_ser_master m (
      .serial_clk (serial_clk),
      .cs_n       (cs_n),
      .sdi        (sdi),
      .sdo        (sdo)
   );

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ****************************************
   // Checking helpers.
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word

   task automatic chk_tap(input string nm, input logic [255:0] e, input logic [255:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_tap

   task automatic summarize;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize

   task automatic note_now;
      dwce_note_s n;
      n = {w[0], w[1], rps, cur_rep, cur_chk};
      notes.push_back(n);
      ->frame_done;
   endtask : note_now

   // ****************************************
   // Driver with reference model.
   // ****************************************
   task automatic run(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d,
                      input int nb);
      logic [15:0] rep;
      logic        gang;
      int          k;
      rep     = {c, a, d};
      m.send(rep, nb);
      cur_rep = prev_rep;
      cur_chk = rep_ok;
      rep_ok  = (nb == WORD_W);
      if (nb == WORD_W) begin
         gang = c inside {CMD_SHRA, CMD_DECA, CMD_RSTA, CMD_SHLA, CMD_INCA};
         for (k = 0; k < 2; k++) begin
            if (gang || k == int'(a[0])) begin
               case (c)
                  CMD_SHR1, CMD_SHRA: w[k] = w[k] >> 1;
                  CMD_DEC1, CMD_DECA: w[k] = (w[k] == CODE_ZERO) ? w[k] : w[k] - 8'h01;
                  CMD_SHL1, CMD_SHLA: w[k] = (w[k] == CODE_ZERO) ? CODE_ONE :
                                             (w[k] >= CODE_MID) ? CODE_FULL : w[k] << 1;
                  CMD_INC1, CMD_INCA: w[k] = (w[k] == CODE_FULL) ? w[k] : w[k] + 8'h01;
                  CMD_RST1, CMD_RSTA: w[k] = nv[k];
                  CMD_WRW:            w[k] = d;
                  default: ;
               endcase
            end
         end
         case (c)
            CMD_NOP:  rps = 1'b0;
            CMD_RST1: rps = 1'b1;
            CMD_SAVE: nv[a[0]] = w[a[0]];
            CMD_WRNV: nv[a] = d;
            CMD_RDNV: rep[7:0] = nv[a];
            CMD_RDW:  rep[7:0] = w[a[0]];
            default: ;
         endcase
         prev_rep = rep;
      end
      note_now();
   endtask : run

   initial begin : watch
      dwce_note_s n;
      forever begin
         @(frame_done);
         n = notes.pop_front();
         chk_word("wiper ch1", {8'h00, n.w1}, {8'h00, wiper_code_ch1});
         chk_word("wiper ch2", {8'h00, n.w2}, {8'h00, wiper_code_ch2});
         chk_word("power state", {15'h0000, n.rps}, {15'h0000, read_power_state});
         chk_tap("taps ch1", 256'h1 << n.w1, tap_sel_ch1);
         chk_tap("taps ch2", 256'h1 << n.w2, tap_sel_ch2);
         if (n.chk) begin
            chk_word("reply", n.rep, m.reply_seen);
         end
      end
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         error_cnt++;
         summarize();
      end
   end

   // ****************************************
   // Main sequence.
   // ****************************************
   initial begin : main
      int i;
      logic [3:0] c;
      error_cnt = 0;
      tests_run = 0;
      cycles    = 0;
      sys_rst   = 1'b1;
      seed      = 32'h31a1;
      w[0]      = NV_RESET_WIPER;
      w[1]      = NV_RESET_WIPER;
      for (i = 0; i < NV_DEPTH; i++) nv[i] = (i < 2) ? NV_RESET_WIPER : NV_RESET_SPARE;
      rps      = 1'b0;
      prev_rep = REPLY_RESET;
      rep_ok   = 1'b1;
      cur_rep  = REPLY_RESET;
      cur_chk  = 1'b0;
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      note_now();
      run(CMD_WRW, 4'h0, 8'h00, 16);
      for (i = 0; i < 10; i++) run(CMD_SHL1, 4'h0, 8'h5a, 16);
      run(CMD_WRW, 4'h1, 8'h03, 16);
      run(CMD_SHR1, 4'h1, 8'hff, 16);
      run(CMD_SHRA, 4'h0, 8'h00, 16);
      run(CMD_SHRA, 4'h0, 8'h00, 16);
      run(CMD_DECA, 4'h0, 8'h00, 16);
      run(CMD_INCA, 4'h0, 8'h00, 16);
      run(CMD_WRW, 4'h0, 8'hff, 16);
      run(CMD_INC1, 4'h0, 8'h00, 16);
      run(CMD_SHLA, 4'h0, 8'h00, 16);
      run(CMD_DEC1, 4'h1, 8'h00, 16);
      run(CMD_WRW, 4'h0, 8'h81, 16);
      run(CMD_SHL1, 4'h0, 8'h00, 16);
      for (i = 2; i < NV_DEPTH; i++) begin
         seed = xs(seed);
         run(CMD_WRNV, i[3:0], seed[7:0], 16);
      end
      for (i = 0; i < NV_DEPTH; i++) run(CMD_RDNV, i[3:0], 8'h00, 16);
      run(CMD_SAVE, 4'h0, 8'h00, 16);
      run(CMD_WRW, 4'h0, 8'h11, 16);
      run(CMD_RDW, 4'h0, 8'h00, 16);
      run(CMD_RST1, 4'h0, 8'h00, 16);
      run(CMD_RSTA, 4'h0, 8'h00, 16);
      run(CMD_NOP, 4'h0, 8'h00, 16);
      run(CMD_WRW, 4'h1, 8'h77, 8);
      for (i = 0; i < 40; i++) begin
         seed = xs(seed);
         c    = seed[15:12];
         run(c, (c == CMD_WRNV || c == CMD_RDNV) ? seed[11:8] : {3'b000, seed[8]},
             seed[7:0], 16);
      end
      #40;
      summarize();
   end
endmodule : dual_wiper_command_engine_test

//--- dwce_core.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Code 14 increments the selected wiper by one.
// - Code 15 increments both wipers by one from their present values.
// - Higher wiper code moves the tap away from terminal B.
// - Step-down acts on one (4) or both (5); step-up on one (12) or both (13).
// - Step-up of a code from 1 to 127 doubles the wiper value by a left shift.
// - Step-up from midscale or above loads full scale 255.
// - A wiper at 255 stays at 255 under further step-up.
// - Step-up of a zero wiper loads code 1.
// - Step-down shifts right one bit, dropping the low bit.
// - Decrements stop at zero, increments at all ones; no wrap.
// - Saved settings load into the wipers at power-on, code 1 and code 8.
// - Code 3 writes a spare byte from data; code 9 reads it back.
// - Every nonvolatile location holds exactly one byte.
// - After code 1 the read power state stays until a code 0.
// - Store address 0 and 1 are saved settings, 2 to 15 spare bytes.
// - Wiper address 0 selects channel 1, address 1 channel 2.
// - Each wiper code drives exactly one of 256 tap selects.
// - A command executes only when chip select returns high.
// - Step and shift commands ignore the data byte.
module dwce_core (
   // Clock and reset.
   input  wire logic                         ref_clk,
   input  wire logic                         sys_rst,
   // Serial command port.
   input  wire logic                         serial_clk,
   input  wire logic                         cs_n,
   input  wire logic                         sdi,
   output wire logic                         sdo,
   // Wiper state.
   output logic [dwce_pkg::CODE_W-1:0]       wiper_code_ch1,
   output logic [dwce_pkg::CODE_W-1:0]       wiper_code_ch2,
   output logic [dwce_pkg::TAPS-1:0]         tap_sel_ch1,
   output logic [dwce_pkg::TAPS-1:0]         tap_sel_ch2,
   // Power state.
   output logic                              read_power_state
);
   import dwce_pkg::*;

   // ****************************************
   // Declarations.
   // ****************************************
   dwce_link_if lnk ();

   logic              cs_meta_reg;
   logic              cs_sync_reg;
   logic              cs_prev_reg;
   logic              exec_pulse;
   logic              exec_ok;
   logic              por_pend_reg;
   logic              upd_any;
   logic [3:0]        cmd;
   logic [3:0]        addr;
   logic              channel_select_bit;
   logic [7:0]        dbyte;
   logic [7:0]        reply_byte;
   logic [7:0]        sel_wiper;
   logic [7:0]        wiper_reg [CHANNELS];
   logic [7:0]        nv_byte_store [NV_DEPTH];
   logic [TAPS-1:0]   tap_reg [CHANNELS];
   logic              read_state_reg;
   logic [WORD_W-1:0] reply_reg;

   // ****************************************
   // Serial link on its own clock.
   // ****************************************
   dwce_link_rx u_link (
      .serial_clk (serial_clk),
      .cs_n       (cs_n),
      .sdi        (sdi),
      .sdo        (sdo),
      .lnk        (lnk.link)
   );

   // ****************************************
   // Chip select synchroniser and execute strobe.
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cs_meta_reg <= 1'b1;
         cs_sync_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
      end else begin
         cs_meta_reg <= cs_n;
         cs_sync_reg <= cs_meta_reg;
         cs_prev_reg <= cs_sync_reg;
      end
   end

   // The link word is static while select is high, so it is read directly.
   assign exec_pulse = cs_sync_reg & ~cs_prev_reg;
   assign exec_ok    = exec_pulse & lnk.word_ok & ~por_pend_reg;
   assign upd_any    = exec_ok | por_pend_reg;

   // ****************************************
   // Command word fields.
   // ****************************************
   assign cmd                = lnk.cmd_word[CMD_LSB+3:CMD_LSB];
   assign addr               = lnk.cmd_word[ADDR_LSB+3:ADDR_LSB];
   assign channel_select_bit = addr[0];
   assign dbyte              = lnk.cmd_word[7:0];
   assign sel_wiper          = wiper_reg[channel_select_bit];

   // ****************************************
   // Wiper arithmetic.
   // ****************************************
   function automatic logic [7:0] dwce_apply(
      input logic [3:0] c,
      input logic [7:0] w,
      input logic [7:0] d
   );
      logic [7:0] r;
      r = w;
      case (c)
         CMD_SHR1, CMD_SHRA: begin
            r = {1'b0, w[7:1]};
         end
         CMD_DEC1, CMD_DECA: begin
            r = (w == CODE_ZERO) ? w : w - CODE_ONE;
         end
         CMD_SHL1, CMD_SHLA: begin
            if (w == CODE_ZERO) begin
               r = CODE_ONE;
            end else if (w >= CODE_MID) begin
               r = CODE_FULL;
            end else begin
               r = {w[6:0], 1'b0};
            end
         end
         CMD_INC1, CMD_INCA: begin
            r = (w == CODE_FULL) ? w : w + CODE_ONE;
         end
         CMD_WRW: begin
            r = d;
         end
         default: begin
            r = w;
         end
      endcase
      return r;
   endfunction : dwce_apply

   function automatic logic dwce_single(input logic [3:0] c);
      return (c == CMD_SHR1) || (c == CMD_DEC1) || (c == CMD_SHL1) ||
             (c == CMD_INC1) || (c == CMD_WRW);
   endfunction : dwce_single

   function automatic logic dwce_ganged(input logic [3:0] c);
      return (c == CMD_SHRA) || (c == CMD_DECA) || (c == CMD_SHLA) ||
             (c == CMD_INCA);
   endfunction : dwce_ganged

   // ****************************************
   // Power-on restore request.
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         por_pend_reg <= 1'b1;
      end else begin
         por_pend_reg <= 1'b0;
      end
   end

   // ****************************************
   // Per-channel wiper registers and tap decode.
   // ****************************************
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      logic hit;
      logic restore;

      always_comb begin
         hit     = exec_ok && (dwce_ganged(cmd) ||
                   (dwce_single(cmd) && (channel_select_bit == 1'(ch))));
         restore = exec_ok && ((cmd == CMD_RSTA) ||
                   ((cmd == CMD_RST1) && (channel_select_bit == 1'(ch))));
      end

      always_ff @(posedge ref_clk) begin
         if (sys_rst) begin
            wiper_reg[ch] <= NV_RESET_WIPER;
         end else if (por_pend_reg || restore) begin
            wiper_reg[ch] <= nv_byte_store[ch];
         end else if (hit) begin
            wiper_reg[ch] <= dwce_apply(cmd, wiper_reg[ch], dbyte);
         end
      end

      // Tap 0 sits at terminal B; one switch closes per code.
      always_ff @(posedge ref_clk) begin
         if (sys_rst) begin
            tap_reg[ch] <= {TAPS{1'b0}};
         end else begin
            tap_reg[ch] <= TAPS'(1) << wiper_reg[ch];
         end
      end
   end

   assign wiper_code_ch1 = wiper_reg[0];
   assign wiper_code_ch2 = wiper_reg[1];
   assign tap_sel_ch1    = tap_reg[0];
   assign tap_sel_ch2    = tap_reg[1];

   // ****************************************
   // Nonvolatile byte store.
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NV_DEPTH; i++) begin
            nv_byte_store[i] <= (i < CHANNELS) ? NV_RESET_WIPER : NV_RESET_SPARE;
         end
      end else if (exec_ok && (cmd == CMD_SAVE)) begin
         nv_byte_store[channel_select_bit] <= sel_wiper;
      end else if (exec_ok && (cmd == CMD_WRNV)) begin
         nv_byte_store[addr] <= dbyte;
      end
   end

   // ****************************************
   // Read power state.
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         read_state_reg <= 1'b0;
      end else if (exec_ok && (cmd == CMD_RST1)) begin
         read_state_reg <= 1'b1;
      end else if (exec_ok && (cmd == CMD_NOP)) begin
         read_state_reg <= 1'b0;
      end
   end

   assign read_power_state = read_state_reg;

   // ****************************************
   // Reply word shifted out in the next frame.
   // ****************************************
   always_comb begin
      reply_byte = dbyte;
      if (cmd == CMD_RDNV) begin
         reply_byte = nv_byte_store[addr];
      end else if (cmd == CMD_RDW) begin
         reply_byte = sel_wiper;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reply_reg <= REPLY_RESET;
      end else if (exec_ok) begin
         reply_reg <= {lnk.cmd_word[WORD_W-1:8], reply_byte};
      end
   end

   assign lnk.reply_word = reply_reg;

   // ****************************************
   // Assertions.
   // ****************************************
   default clocking cb @(posedge ref_clk);
   endclocking

   default disable iff (sys_rst);

   property p_inc_one;
      (exec_ok && cmd == CMD_INC1 && !channel_select_bit && wiper_reg[0] != CODE_FULL)
      |=> wiper_code_ch1 == $past(wiper_code_ch1) + CODE_ONE;
   endproperty
   a_inc_one: assert property (p_inc_one) else $error("single increment wrong");

   property p_inc_all;
      (exec_ok && cmd == CMD_INCA && wiper_reg[0] != CODE_FULL &&
       wiper_reg[1] != CODE_FULL)
      |=> (wiper_code_ch1 == $past(wiper_code_ch1) + CODE_ONE) &&
          (wiper_code_ch2 == $past(wiper_code_ch2) + CODE_ONE);
   endproperty
   a_inc_all: assert property (p_inc_all) else $error("ganged increment wrong");

   property p_tap_follow;
      !sys_rst |=> tap_sel_ch2 == (TAPS'(1) << $past(wiper_code_ch2));
   endproperty
   a_tap_follow: assert property (p_tap_follow) else $error("tap not at code");

   property p_single_other;
      (exec_ok && cmd == CMD_SHR1 && !channel_select_bit) |=> $stable(wiper_code_ch2);
   endproperty
   a_single_other: assert property (p_single_other) else $error("other wiper moved");

   property p_shl_double;
      (exec_ok && cmd == CMD_SHL1 && channel_select_bit && wiper_reg[1] != CODE_ZERO &&
       wiper_reg[1] < CODE_MID)
      |=> wiper_code_ch2 == 8'($past(wiper_code_ch2) << 1);
   endproperty
   a_shl_double: assert property (p_shl_double) else $error("step-up not doubled");

   property p_shl_full;
      (exec_ok && cmd == CMD_SHLA && wiper_reg[0] >= CODE_MID) |=> wiper_code_ch1 == CODE_FULL;
   endproperty
   a_shl_full: assert property (p_shl_full) else $error("step-up not full");

   property p_shl_zero;
      (exec_ok && cmd == CMD_SHLA && wiper_reg[1] == CODE_ZERO) |=> wiper_code_ch2 == CODE_ONE;
   endproperty
   a_shl_zero: assert property (p_shl_zero) else $error("zero step-up not one");

   property p_shr;
      (exec_ok && cmd == CMD_SHRA) |=> wiper_code_ch1 == ($past(wiper_code_ch1) >> 1);
   endproperty
   a_shr: assert property (p_shr) else $error("step-down wrong");

   property p_dec_floor;
      (exec_ok && cmd == CMD_DECA && wiper_reg[0] == CODE_ZERO) |=> wiper_code_ch1 == CODE_ZERO;
   endproperty
   a_dec_floor: assert property (p_dec_floor) else $error("decrement wrapped");

   property p_restore;
      (exec_ok && cmd == CMD_RSTA) |=> wiper_code_ch2 == nv_byte_store[1];
   endproperty
   a_restore: assert property (p_restore) else $error("restore missed");

   property p_spare_write;
      (exec_ok && cmd == CMD_WRNV) ##1 !exec_ok [*2]
      |-> nv_byte_store[$past(addr, 2)] == $past(dbyte, 2);
   endproperty
   a_spare_write: assert property (p_spare_write) else $error("spare write lost");

   property p_read_hold;
      (read_state_reg && !(exec_ok && cmd == CMD_NOP)) |=> read_power_state;
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("read state dropped");

   property p_onehot;
      !sys_rst |=> $onehot(tap_sel_ch1);
   endproperty
   a_onehot: assert property (p_onehot) else $error("tap select not one-hot");

   property p_exec_only;
      $changed(wiper_code_ch1) |-> $past(upd_any);
   endproperty
   a_exec_only: assert property (p_exec_only) else $error("wiper moved unasked");

   property p_direct_write;
      (exec_ok && cmd == CMD_WRW && channel_select_bit) |=> wiper_code_ch2 == $past(dbyte);
   endproperty
   a_direct_write: assert property (p_direct_write) else $error("direct write lost");

   c_inc: cover property (exec_ok && cmd == CMD_INCA);
   c_restore_nop: cover property (read_state_reg ##[1:200] !read_state_reg);
   c_readback: cover property (exec_ok && cmd == CMD_RDNV ##1 reply_reg != REPLY_RESET);
   c_full: cover property (exec_ok && cmd == CMD_SHL1 ##1 wiper_code_ch1 == CODE_FULL);

endmodule : dwce_core

//--- dwce_link_if.sv
`timescale 1ns/1ns
interface dwce_link_if;
   logic [15:0] cmd_word;
   logic        word_ok;
   logic [15:0] reply_word;

   modport link (
      output cmd_word,
      output word_ok,
      input  reply_word
   );

   modport core (
      input  cmd_word,
      input  word_ok,
      output reply_word
   );
endinterface : dwce_link_if

//--- dwce_link_rx.sv
`timescale 1ns/1ns
module dwce_link_rx (
   // Serial pins.
   input  wire logic serial_clk,
   input  wire logic cs_n,
   input  wire logic sdi,
   output wire logic sdo,
   // Core side.
   dwce_link_if.link lnk
);
   import dwce_pkg::*;

   logic [WORD_W-1:0] shift_reg;
   logic [CNT_W-1:0]  bit_cnt_reg;
   logic              started_reg;

   // ****************************************
   // Frame start flag, ended by the frame's own select.
   // ****************************************
   always_ff @(posedge serial_clk or posedge cs_n) begin
      if (cs_n) begin
         started_reg <= 1'b0;
      end else begin
         started_reg <= 1'b1;
      end
   end

   // ****************************************
   // Shift register; the first edge loads the reply word.
   // ****************************************
   always_ff @(posedge serial_clk) begin
      if (!cs_n) begin
         if (!started_reg) begin
            shift_reg   <= {lnk.reply_word[WORD_W-2:0], sdi};
            bit_cnt_reg <= CNT_W'(1);
         end else begin
            shift_reg <= {shift_reg[WORD_W-2:0], sdi};
            if (bit_cnt_reg != FRAME_BITS) begin
               bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
            end
         end
      end
   end

   // The word and count stay frozen once the clock stops after a frame.
   assign lnk.cmd_word = shift_reg;
   assign lnk.word_ok  = (bit_cnt_reg == FRAME_BITS);
   assign sdo = started_reg ? shift_reg[WORD_W-1] : lnk.reply_word[WORD_W-1];

endmodule : dwce_link_rx

//--- dwce_pkg.sv
package dwce_pkg;

   // ****************************************
   // Command word layout.
   // ****************************************
   localparam int WORD_W   = 16;
   localparam int CODE_W   = 8;
   localparam int CMD_LSB  = 12;
   localparam int ADDR_LSB = 8;
   localparam int CNT_W    = 5;
   localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;

   // ****************************************
   // Command codes.
   // ****************************************
   typedef enum logic [3:0] {
      CMD_NOP   = 4'h0,
      CMD_RST1  = 4'h1,
      CMD_SAVE  = 4'h2,
      CMD_WRNV  = 4'h3,
      CMD_SHR1  = 4'h4,
      CMD_SHRA  = 4'h5,
      CMD_DEC1  = 4'h6,
      CMD_DECA  = 4'h7,
      CMD_RSTA  = 4'h8,
      CMD_RDNV  = 4'h9,
      CMD_RDW   = 4'ha,
      CMD_WRW   = 4'hb,
      CMD_SHL1  = 4'hc,
      CMD_SHLA  = 4'hd,
      CMD_INC1  = 4'he,
      CMD_INCA  = 4'hf
   } dwce_cmd_e;

   // ****************************************
   // Storage map and reset values.
   // ****************************************
   localparam int CHANNELS = 2;
   localparam int NV_DEPTH = 16;
   localparam int TAPS     = 256;
   localparam logic [3:0] NV_ADDR_CH1 = 4'h0;
   localparam logic [3:0] NV_ADDR_CH2 = 4'h1;
   localparam logic [3:0] WIPER_ADDR_CH1 = 4'h0;
   localparam logic [3:0] WIPER_ADDR_CH2 = 4'h1;
   localparam logic [7:0] CODE_ZERO = 8'h00;
   localparam logic [7:0] CODE_ONE  = 8'h01;
   localparam logic [7:0] CODE_MID  = 8'h80;
   localparam logic [7:0] CODE_FULL = 8'hff;
   localparam logic [7:0] NV_RESET_WIPER = 8'h80;
   localparam logic [7:0] NV_RESET_SPARE = 8'h00;
   localparam logic [15:0] REPLY_RESET = 16'h0000;

endpackage : dwce_pkg

//--- dwce_ser_master.sv
`timescale 1ns/1ns
module dwce_ser_master (
   // Serial pins.
   output logic      serial_clk,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic sdo
);
   logic [15:0] reply_seen;

   // Select rises just after time zero, so the frame logic sees a clean edge and clears.
   initial begin
      serial_clk = 1'b0;
      sdi        = 1'b0;
      reply_seen = 16'h0000;
      #1;
      cs_n       = 1'b1;
   end

   // ****************************************
   // Frame driver.
   // ****************************************
   // Sends the low nb bits MSB first; the clock stands low between frames.
   task automatic send(input logic [15:0] word, input int nb);
      int i;
      cs_n = 1'b0;
      for (i = nb - 1; i >= 0; i--) begin
         sdi = word[i];
         #15;
         reply_seen = {reply_seen[14:0], sdo};
         serial_clk = 1'b1;
         #15;
         serial_clk = 1'b0;
      end
      #15;
      cs_n = 1'b1;
      // The data line is inverted, so it no longer shows the last bit.
      sdi = ~sdi;
      #480;
   endtask : send
endmodule : dwce_ser_master
